// file: src/ubf_top.sv
// uart baud rate generator, frame formatter, minimal shifters and avalon register slave
// ==========================================================
// Overview of operation
// R1: free running 8-bit counter on system clock, period of divisor plus one clocks; speed bit 0 adds a divide by four
// R2: speed bit 0 gives bit rate of clock over 64 times divisor plus one
// R3: speed bit 1 gives bit rate of clock over 16 times divisor plus one
// R4: divisor is the unsigned 8-bit register value, 0 to 255 all valid
// R5: line is NRZ, each level held one full bit period
// R6: frame is one start bit, eight or nine data bits, one or two stop bits
// R7: even, odd or no parity supported in hardware
// R8: after reset format is eight data bits, no parity, one stop bit
// R9: word length, parity type, parity enable, stop count are fields of first control
// R10: data bits go least significant first, right after the start bit
// R11: transmitter and receiver independent but share one format and one rate
// R12: every transmitted frame carries its stop bits
// R13: word-length field set gives nine-bit words, ninth bit most significant
// R14: stop-count field 1 gives two stop bits, 0 gives one
// R15: parity-type field 0 gives even parity, 1 gives odd
// R16: parity only when enabled; then last data position of word carries parity
// R17: counter reloads from divisor on expiry, one tick each; new divisor at next reload
`timescale 1ns/1ns
module ubf_top
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // avalon-mm slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // serial line
    input  wire logic        i_rxd,
    output logic             o_txd
);

    // ==========================================================
    // registers
    logic [7:0]          div_q;
    ubf_pkg::ubf_fmt_t   fmt_q;
    logic                hs_q;
    logic                tx_en_q;
    logic                rx_en_q;
    logic                wait_q;
    logic [31:0]         rdata_q;

    wire req     = i_avs_read | i_avs_write;
    wire accept  = req & ~wait_q;
    wire wr_acc  = i_avs_write & ~wait_q & i_avs_byteenable[0];
    wire rd_acc  = i_avs_read & ~wait_q;
    wire [4:0] adr = {i_avs_address[4:2], 2'b00};
    wire wr_div  = wr_acc & (adr == ubf_pkg::UBF_OFS_DIV);
    wire wr_ctl1 = wr_acc & (adr == ubf_pkg::UBF_OFS_CTL1);
    wire wr_ctl2 = wr_acc & (adr == ubf_pkg::UBF_OFS_CTL2);
    wire wr_data = wr_acc & (adr == ubf_pkg::UBF_OFS_DATA);
    wire rd_data = rd_acc & (adr == ubf_pkg::UBF_OFS_DATA);

    // ==========================================================
    // baud generator
    logic [7:0] div_cnt_q;
    logic [1:0] pre_q;
    wire div_tick = (div_cnt_q == 8'h00);
    // low speed adds a divide by four so both modes share the x16 oversample
    wire os_tick  = div_tick & (hs_q | (pre_q == ubf_pkg::UBF_PRE_LAST)); // R2 R3

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_cnt_q <= 8'h00;
            pre_q     <= 2'h0;
        end
        else
        begin
            div_cnt_q <= div_tick ? div_q : div_cnt_q - 8'h01; // R1 R4 R17
            pre_q     <= div_tick ? pre_q + 2'h1 : pre_q;
        end
    end

    // ==========================================================
    // register file
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q   <= ubf_pkg::UBF_DIV_RST;
            fmt_q   <= ubf_pkg::UBF_FMT_RST; // R8
            hs_q    <= 1'b0;
            tx_en_q <= 1'b0;
            rx_en_q <= 1'b0;
        end
        else
        begin
            if (wr_div)
                div_q <= i_avs_writedata[7:0];
            if (wr_ctl1)
                fmt_q <= {i_avs_writedata[ubf_pkg::UBF_CTL1_NINE_BIT], i_avs_writedata[ubf_pkg::UBF_CTL1_PAREN_BIT],
                          i_avs_writedata[ubf_pkg::UBF_CTL1_PODD_BIT], i_avs_writedata[ubf_pkg::UBF_CTL1_STOP2_BIT]}; // R9
            if (wr_ctl2)
            begin
                tx_en_q <= i_avs_writedata[ubf_pkg::UBF_CTL2_TXEN_BIT];
                rx_en_q <= i_avs_writedata[ubf_pkg::UBF_CTL2_RXEN_BIT];
                hs_q    <= i_avs_writedata[ubf_pkg::UBF_CTL2_HS_BIT];
            end
        end
    end

    // ==========================================================
    // transmitter
    ubf_pkg::ubf_tx_st_t tx_st_q;
    logic [11:0] tx_sh_q;
    logic [3:0]  tx_cnt_q;
    logic [3:0]  tx_os_q;
    logic        txd_q;

    wire [8:0] tx_word  = {i_avs_writedata[8] & i_avs_byteenable[1], i_avs_writedata[7:0]};
    wire       tx_par   = (fmt_q.nine ? ^tx_word[7:0] : ^tx_word[6:0]) ^ fmt_q.par_odd; // R15
    wire       tx_top   = fmt_q.par_en ? tx_par : (fmt_q.nine ? tx_word[8] : tx_word[7]); // R16 R13
    // eight-bit words put a stop level where the ninth bit would sit
    wire [8:0] tx_data9 = fmt_q.nine ? {tx_top, tx_word[7:0]} : {1'b1, tx_top, tx_word[6:0]};
    wire [11:0] tx_frame = {2'b11, tx_data9, 1'b0}; // R6 R10 R12
    wire [3:0] tx_len   = ubf_pkg::UBF_FRAME_MIN + {3'h0, fmt_q.nine} + {3'h0, fmt_q.two_stop}; // R14
    wire tx_load  = wr_data & tx_en_q & (tx_st_q == ubf_pkg::UBF_TX_IDLE);
    wire tx_shift = (tx_st_q == ubf_pkg::UBF_TX_SHIFT) & os_tick & (tx_os_q == ubf_pkg::UBF_OS_LAST);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_st_q  <= ubf_pkg::UBF_TX_IDLE;
            tx_sh_q  <= 12'hFFF;
            tx_cnt_q <= 4'h0;
            tx_os_q  <= 4'h0;
            txd_q    <= 1'b1;
        end
        else
        begin
            txd_q <= (tx_st_q == ubf_pkg::UBF_TX_SHIFT) ? tx_sh_q[0] : 1'b1; // R5
            case (tx_st_q)
                ubf_pkg::UBF_TX_IDLE:
                begin
                    if (tx_load)
                    begin
                        tx_sh_q  <= tx_frame;
                        tx_cnt_q <= tx_len;
                        tx_os_q  <= 4'h0;
                        tx_st_q  <= ubf_pkg::UBF_TX_SHIFT;
                    end
                end
                ubf_pkg::UBF_TX_SHIFT:
                begin
                    if (!tx_en_q)
                        tx_st_q <= ubf_pkg::UBF_TX_IDLE;
                    else if (os_tick)
                        tx_os_q <= tx_os_q + 4'h1;
                    if (tx_en_q && tx_shift)
                    begin
                        tx_sh_q  <= {1'b1, tx_sh_q[11:1]}; // R10
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        if (tx_cnt_q == 4'h1)
                            tx_st_q <= ubf_pkg::UBF_TX_IDLE;
                    end
                end
                default: tx_st_q <= ubf_pkg::UBF_TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // receiver
    ubf_pkg::ubf_rx_st_t rx_st_q;
    logic       rx_s1_q;
    logic       rx_s2_q;
    logic [3:0] rx_os_q;
    logic [3:0] rx_bit_q;
    logic [8:0] rx_sh_q;
    logic [8:0] rx_word_q;
    logic       rx_valid_q;
    logic       rx_perr_q;
    logic       rx_ferr_q;

    wire       rx_mid    = os_tick & (rx_os_q == ubf_pkg::UBF_OS_MID);
    wire       rx_samp   = os_tick & (rx_os_q == ubf_pkg::UBF_OS_LAST);
    wire [3:0] rx_last   = fmt_q.nine ? 4'h8 : 4'h7; // R11 R13
    wire [8:0] rx_word   = fmt_q.nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    wire       rx_done   = (rx_st_q == ubf_pkg::UBF_RX_STOP) & rx_samp & rx_en_q;
    wire       rx_par_ng = fmt_q.par_en & ((^rx_word) != fmt_q.par_odd); // R7 R16

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= i_rxd;
            rx_s2_q <= rx_s1_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_st_q  <= ubf_pkg::UBF_RX_IDLE;
            rx_os_q  <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= 9'h000;
        end
        else if (!rx_en_q)
            rx_st_q <= ubf_pkg::UBF_RX_IDLE;
        else
        begin
            if (os_tick)
                rx_os_q <= rx_os_q + 4'h1;
            case (rx_st_q)
                ubf_pkg::UBF_RX_IDLE:
                begin
                    rx_os_q <= 4'h0;
                    if (!rx_s2_q)
                        rx_st_q <= ubf_pkg::UBF_RX_START;
                end
                ubf_pkg::UBF_RX_START:
                begin
                    // realign to mid start so later samples land mid bit
                    if (rx_mid)
                    begin
                        rx_os_q  <= 4'h0;
                        rx_bit_q <= 4'h0;
                        rx_st_q  <= rx_s2_q ? ubf_pkg::UBF_RX_IDLE : ubf_pkg::UBF_RX_DATA;
                    end
                end
                ubf_pkg::UBF_RX_DATA:
                begin
                    if (rx_samp)
                    begin
                        rx_sh_q  <= {rx_s2_q, rx_sh_q[8:1]}; // R10
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == rx_last)
                            rx_st_q <= ubf_pkg::UBF_RX_STOP;
                    end
                end
                ubf_pkg::UBF_RX_STOP:
                begin
                    if (rx_samp)
                        rx_st_q <= ubf_pkg::UBF_RX_IDLE;
                end
                default: rx_st_q <= ubf_pkg::UBF_RX_IDLE;
            endcase
        end
    end

    // a frame landing in the same cycle as the read keeps valid set
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_word_q  <= 9'h000;
            rx_valid_q <= 1'b0;
            rx_perr_q  <= 1'b0;
            rx_ferr_q  <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_word_q  <= rx_word;
            rx_valid_q <= 1'b1;
            rx_perr_q  <= rx_par_ng;
            rx_ferr_q  <= ~rx_s2_q; // R6
        end
        else if (rd_data)
            rx_valid_q <= 1'b0;
    end

    // ==========================================================
    // avalon answer: one wait cycle, then data with waitrequest low
    wire [31:0] rd_mux =
        (adr == ubf_pkg::UBF_OFS_DIV)  ? {24'h000000, div_q} :
        (adr == ubf_pkg::UBF_OFS_CTL1) ? {24'h000000, fmt_q.nine, 1'b0, fmt_q.par_en, fmt_q.par_odd,
                                          fmt_q.two_stop, 3'h0} :
        (adr == ubf_pkg::UBF_OFS_CTL2) ? {24'h000000, tx_en_q, rx_en_q, hs_q, 5'h00} :
        (adr == ubf_pkg::UBF_OFS_DATA) ? {23'h000000, rx_word_q} :
        (adr == ubf_pkg::UBF_OFS_STAT) ? {28'h0000000, rx_ferr_q, rx_perr_q, rx_valid_q,
                                          tx_st_q == ubf_pkg::UBF_TX_SHIFT} :
        32'h00000000;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            wait_q  <= ~(req & wait_q);
            rdata_q <= (i_avs_read & wait_q) ? rd_mux : rdata_q;
        end
    end

    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata    = rdata_q;
    assign o_txd             = txd_q;

    // ==========================================================
    // checks
    sequence s_load;
        tx_load;
    endsequence

    sequence s_start_out;
        ##1 (tx_st_q == ubf_pkg::UBF_TX_SHIFT) ##1 !o_txd;
    endsequence

    div_reload_a: assert property (@(posedge i_clk) disable iff (i_rst) div_tick |=> div_cnt_q == $past(div_q)) // R17
        else $error("divisor counter did not reload");
    div_count_a: assert property (@(posedge i_clk) disable iff (i_rst) !div_tick |=> div_cnt_q == $past(div_cnt_q) - 8'h01) // R1
        else $error("divisor counter did not count down");
    low_speed_a: assert property (@(posedge i_clk) disable iff (i_rst) (os_tick && !hs_q) |=> pre_q == 2'h0) // R2
        else $error("low speed tick not every fourth expiry");
    high_speed_a: assert property (@(posedge i_clk) disable iff (i_rst) (div_tick && hs_q) |-> os_tick) // R3
        else $error("high speed missed a tick");
    start_bit_a: assert property (@(posedge i_clk) disable iff (i_rst) s_load |-> s_start_out) // R6
        else $error("frame did not open with a start bit");
    tx_parity_a: assert property (@(posedge i_clk) disable iff (i_rst) (tx_load && fmt_q.par_en && !fmt_q.nine) |=> (^tx_sh_q[8:1]) == $past(fmt_q.par_odd)) // R15
        else $error("parity bit wrong");
    frame_len_a: assert property (@(posedge i_clk) disable iff (i_rst) tx_load |=> tx_cnt_q == 4'hA + {3'h0, $past(fmt_q.nine)} + {3'h0, $past(fmt_q.two_stop)}) // R14
        else $error("frame length wrong");
    lsb_first_a: assert property (@(posedge i_clk) disable iff (i_rst) (tx_shift && tx_en_q) |=> tx_sh_q[0] == $past(tx_sh_q[1])) // R10
        else $error("bits not shifted lsb first");
    idle_high_a: assert property (@(posedge i_clk) disable iff (i_rst) (tx_st_q == ubf_pkg::UBF_TX_IDLE) [*2] |-> o_txd) // R5
        else $error("idle line not high");
    stop_kept_a: assert property (@(posedge i_clk) disable iff (i_rst) (tx_shift && tx_en_q && tx_cnt_q <= 4'h2) |=> tx_sh_q[0]) // R12
        else $error("stop bit missing");
    rx_setwin_a: assert property (@(posedge i_clk) disable iff (i_rst) (rx_done && rd_data) |=> rx_valid_q) // R11
        else $error("receive flag lost on clear");
    bus_ack_a: assert property (@(posedge i_clk) disable iff (i_rst) (req && wait_q) |=> !o_avs_waitrequest ##1 o_avs_waitrequest) // R9
        else $error("bus answer not one cycle");

endmodule

// file: src/ubf_pkg.sv
// shared constants and types for the uart baud and frame format block
package ubf_pkg;

    // ==========================================================
    // clock
    localparam int unsigned UBF_CLK_HZ = 25_000_000;

    // ==========================================================
    // register byte offsets
    localparam logic [4:0] UBF_OFS_DIV    = 5'h00;
    localparam logic [4:0] UBF_OFS_CTL1   = 5'h04;
    localparam logic [4:0] UBF_OFS_CTL2   = 5'h08;
    localparam logic [4:0] UBF_OFS_DATA   = 5'h0C;
    localparam logic [4:0] UBF_OFS_STAT   = 5'h10;

    // ==========================================================
    // field positions
    localparam int UBF_CTL1_NINE_BIT  = 7;
    localparam int UBF_CTL1_PAREN_BIT = 5;
    localparam int UBF_CTL1_PODD_BIT  = 4;
    localparam int UBF_CTL1_STOP2_BIT = 3;
    localparam int UBF_CTL2_TXEN_BIT  = 7;
    localparam int UBF_CTL2_RXEN_BIT  = 6;
    localparam int UBF_CTL2_HS_BIT    = 5;
    localparam int UBF_STAT_BUSY_BIT  = 0;
    localparam int UBF_STAT_VALID_BIT = 1;
    localparam int UBF_STAT_PERR_BIT  = 2;
    localparam int UBF_STAT_FERR_BIT  = 3;

    // ==========================================================
    // reset values and counts
    localparam logic [7:0] UBF_DIV_RST    = 8'h00;
    localparam logic [1:0] UBF_PRE_LAST   = 2'h3;
    localparam logic [3:0] UBF_OS_LAST    = 4'hF;
    localparam logic [3:0] UBF_OS_MID     = 4'h7;
    localparam logic [3:0] UBF_FRAME_MIN  = 4'hA;

    // ==========================================================
    // types
    typedef struct packed {
        logic nine;
        logic par_en;
        logic par_odd;
        logic two_stop;
    } ubf_fmt_t;

    localparam ubf_fmt_t UBF_FMT_RST = '{nine: 1'b0, par_en: 1'b0, par_odd: 1'b0, two_stop: 1'b0};

    typedef enum logic [1:0] {
        UBF_TX_IDLE  = 2'b01,
        UBF_TX_SHIFT = 2'b10
    } ubf_tx_st_t;

    typedef enum logic [3:0] {
        UBF_RX_IDLE  = 4'b0001,
        UBF_RX_START = 4'b0010,
        UBF_RX_DATA  = 4'b0100,
        UBF_RX_STOP  = 4'b1000
    } ubf_rx_st_t;

endpackage

// file: tb/ubf_remote.sv
// remote serial device model on the far side of the line pins
`timescale 1ns/1ns
module ubf_remote
(
    // clock
    input  wire logic i_clk,
    // serial line
    input  wire logic i_txd,
    output logic      o_rxd
);
    // ========
    // transmit side, mark level between frames
    initial o_rxd = 1'b1;

    task automatic send(input logic [8:0] w, input int n, input int p, input logic stp);
        for (int i = 0; i < n + 2; i++)
        begin
            @(posedge i_clk);
            o_rxd <= (i == 0) ? 1'b0 : (i <= n) ? w[i-1] : stp;
            repeat (p - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_rxd <= 1'b1;
        repeat (p) @(posedge i_clk);
    endtask

    // ========
    // receive side, mid bit on falling clock so no race with the line
    task automatic recv(input int n, input int p, output logic [8:0] w, output logic stp);
        w = 9'h000;
        @(negedge i_txd);
        repeat (p / 2) @(negedge i_clk);
        for (int i = 0; i < n; i++)
        begin
            repeat (p) @(negedge i_clk);
            w[i] = i_txd;
        end
        repeat (p) @(negedge i_clk);
        stp = i_txd;
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the uart baud and frame format block
`timescale 1ns/1ns
module testbench;
    logic        i_clk;
    logic        i_rst;
    logic [4:0]  i_avs_address;
    logic        i_avs_read;
    logic        i_avs_write;
    logic [3:0]  i_avs_byteenable;
    logic [31:0] i_avs_writedata;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic        i_rxd;
    logic        o_txd;
    logic [31:0] rd;
    int          mismatches;
    int          cmp_count;

    ubf_top dut
    (
        .i_clk            (i_clk),
        .i_rst            (i_rst),
        .i_avs_address    (i_avs_address),
        .i_avs_read       (i_avs_read),
        .i_avs_write      (i_avs_write),
        .i_avs_byteenable (i_avs_byteenable),
        .i_avs_writedata  (i_avs_writedata),
        .o_avs_readdata   (o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_rxd            (i_rxd),
        .o_txd            (o_txd)
    );

    ubf_remote rem
    (
        .i_clk(i_clk),
        .i_txd(o_txd),
        .o_rxd(i_rxd)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // ========
    // common tasks
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // waitrequest and read data are taken at the rising edge that ends the wait
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge i_clk);
        i_avs_address    <= a;
        i_avs_writedata  <= d;
        i_avs_byteenable <= be;
        i_avs_write      <= wr;
        i_avs_read       <= !wr;
        @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0)
            @(posedge i_clk);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp, input logic [31:0] msk);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(nm, exp, rd & msk);
    endtask

    // one word out through the line and, if asked, the same word back in
    task automatic frame(input logic [7:0] c1, input logic [8:0] d, input int p, input logic rx);
        int         n;
        logic       pe;
        logic [8:0] dm;
        logic [8:0] w;
        logic [8:0] got;
        logic       stp;
        n  = c1[ubf_pkg::UBF_CTL1_NINE_BIT] ? 9 : 8;
        pe = c1[ubf_pkg::UBF_CTL1_PAREN_BIT];
        dm = (n == 9) ? 9'h1FF : 9'h0FF;
        if (pe)
            dm = dm >> 1;
        w = d & dm;
        if (pe)
            w[n-1] = ^w ^ c1[ubf_pkg::UBF_CTL1_PODD_BIT];
        wr(ubf_pkg::UBF_OFS_DATA, {23'h0, d});
        rem.recv(n, p, got, stp);
        chk("tx word", {23'h0, w}, {23'h0, got});
        chk("tx stop", 32'h1, {31'h0, stp});
        repeat (p) @(posedge i_clk);
        rdchk("tx busy in second stop", ubf_pkg::UBF_OFS_STAT, {31'h0, c1[ubf_pkg::UBF_CTL1_STOP2_BIT]}, 32'h1);
        repeat (p) @(posedge i_clk);
        if (rx)
        begin
            rem.send(w, n, p, 1'b1);
            rdchk("rx status", ubf_pkg::UBF_OFS_STAT, 32'h2, 32'hE);
            rdchk("rx word", ubf_pkg::UBF_OFS_DATA, {23'h0, w & dm}, {23'h0, dm});
            if (pe)
            begin
                rem.send(w ^ (9'h001 << (n - 1)), n, p, 1'b1);
                rdchk("rx parity error", ubf_pkg::UBF_OFS_STAT, 32'h6, 32'hE);
                bus(1'b0, ubf_pkg::UBF_OFS_DATA, 32'h0, 4'hF);
            end
        end
    endtask

    // ========
    // scenarios
    task automatic t_reset();
        rdchk("divisor", ubf_pkg::UBF_OFS_DIV, 32'h0, 32'hFFFFFFFF);
        rdchk("ctl1", ubf_pkg::UBF_OFS_CTL1, 32'h0, 32'hFFFFFFFF);
        rdchk("ctl2", ubf_pkg::UBF_OFS_CTL2, 32'h0, 32'hFFFFFFFF);
        rdchk("unmapped", 5'h14, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, ubf_pkg::UBF_OFS_DIV, 32'h5A, 4'h0);
        rdchk("divisor lane off", ubf_pkg::UBF_OFS_DIV, 32'h0, 32'hFFFFFFFF);
        wr(ubf_pkg::UBF_OFS_CTL2, 32'hE0);
        frame(8'h00, 9'h0A5, 16, 1'b1);
        rem.send(9'h0F0, 8, 16, 1'b0);
        rdchk("framing error", ubf_pkg::UBF_OFS_STAT, 32'h8, 32'h8);
        bus(1'b0, ubf_pkg::UBF_OFS_DATA, 32'h0, 4'hF);
        $display("test reset done");
    endtask

    task automatic t_formats();
        logic [7:0] fmts [5];
        fmts = '{8'h80, 8'h20, 8'h30, 8'hB8, 8'h08};
        foreach (fmts[i])
        begin
            wr(ubf_pkg::UBF_OFS_CTL1, {24'h0, fmts[i]});
            frame(fmts[i], 9'h1A5, 16, 1'b1);
        end
        $display("test formats done");
    endtask

    task automatic t_rates();
        wr(ubf_pkg::UBF_OFS_CTL1, 32'h0);
        wr(ubf_pkg::UBF_OFS_DIV, 32'h01);
        wr(ubf_pkg::UBF_OFS_CTL2, 32'hC0);
        frame(8'h00, 9'h03C, 128, 1'b1);
        wr(ubf_pkg::UBF_OFS_DIV, 32'hFF);
        wr(ubf_pkg::UBF_OFS_CTL2, 32'hE0);
        frame(8'h00, 9'h05A, 4096, 1'b0);
        wr(ubf_pkg::UBF_OFS_DIV, 32'h00);
        // old count of up to 256 clocks runs out before the new divisor loads
        repeat (256) @(posedge i_clk);
        frame(8'h00, 9'h0C3, 16, 1'b1);
        $display("test rates done");
    endtask

    // ========
    // main sequence
    initial
    begin
        mismatches       = 0;
        cmp_count        = 0;
        i_rst            = 1'b1;
        i_avs_address    = 5'h00;
        i_avs_read       = 1'b0;
        i_avs_write      = 1'b0;
        i_avs_byteenable = 4'h0;
        i_avs_writedata  = 32'h0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_formats();
        t_rates();
        report_and_stop();
    end

    // run needs about 54000 cycles, mostly the slowest divisor frame
    initial
    begin
        repeat (90000) @(posedge i_clk);
        mismatches++;
        report_and_stop();
    end
endmodule
